// ---- hdl/gec_regs.svh ----
// Register map, field positions, reset values and timing counts of the edge counter channel
`ifndef GEC_REGS_SVH
`define GEC_REGS_SVH

// ================================================================
// Register offsets (byte addresses)
`define GEC_ADDR_W        8
`define GEC_OFS_CTRL      8'h00
`define GEC_OFS_HIGH_LIM  8'h04
`define GEC_OFS_CMP_VAL   8'h08
`define GEC_OFS_START_VAL 8'h0c
`define GEC_OFS_COUNT     8'h10
`define GEC_OFS_STATUS    8'h14
`define GEC_OFS_IRQ_STS   8'h18
`define GEC_OFS_IRQ_MASK  8'h1c

// ================================================================
// Control register fields
`define GEC_CTRL_SOFTWARE_GATE_BIT   0
`define GEC_CTRL_LOAD_LO   1
`define GEC_CTRL_LOAD_HI   3
`define GEC_CTRL_EDGE_LO   4
`define GEC_CTRL_EDGE_HI   5
`define GEC_CTRL_CMP_LOWER 6
`define GEC_CTRL_CONTINUE  7
`define GEC_CTRL_IRQ_EN    8
`define GEC_CTRL_SUP_DIAG  9
`define GEC_CTRL_WIRE_DIAG 10
`define GEC_CTRL_FLT_LO    11
`define GEC_CTRL_FLT_HI    13
`define GEC_CTRL_MASK      32'h0000_3fff
`define GEC_CTRL_RST       32'h0000_2000

// ================================================================
// Load command codes, limits, reset values
`define GEC_LOAD_RESUME    3'h0
`define GEC_LOAD_START     3'h2
`define GEC_LOW_LIMIT      32'h0000_0000
`define GEC_HIGH_LIM_RST   32'hffff_ffff
`define GEC_CMP_VAL_RST    32'h0000_0001
`define GEC_START_VAL_RST  32'h0000_0000

// ================================================================
// Interrupt status bits
`define GEC_IRQ_CMP        0
`define GEC_IRQ_LIMIT      1
`define GEC_IRQ_DIAG       2
`define GEC_IRQ_W          3

// ================================================================
// Input filter timing: a 50 us tick, delays in microseconds
`define GEC_CLK_PERIOD_NS  25
`define GEC_TICK_NS        50000
`define GEC_TICK_CYCLES    (`GEC_TICK_NS / `GEC_CLK_PERIOD_NS)
`define GEC_TICK_US        50
`define GEC_DLY0_US        50
`define GEC_DLY1_US        100
`define GEC_DLY2_US        400
`define GEC_DLY3_US        1600
`define GEC_DLY4_US        3200
`define GEC_DLY5_US        12800
`define GEC_DLY6_US        20000

`endif

// ---- hdl/gec_pkg.sv ----
// Shared types of the edge counter channel
package gec_pkg;
	typedef logic [31:0] gec_word_t;
	typedef logic [8:0]  gec_ticks_t;
	typedef enum logic [1:0] {GEC_EDGE_RISE, GEC_EDGE_FALL, GEC_EDGE_BOTH, GEC_EDGE_RSVD} gec_edge_t;
endpackage

// ---- hdl/gec_filter.sv ----
// Input delay filter: accepts a new level only after it stayed stable past the delay
`timescale 1ns/1ps
module gec_filter
	import gec_pkg::*;
(
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             tick_i,
	input  wire logic             level_i,
	input  wire gec_pkg::gec_ticks_t limit_i,
	output logic                  level_o,
	output logic                  rise_o,
	output logic                  fall_o
);
	gec_ticks_t stable_cnt;
	logic       accept;

	// Accept on the tick after limit_i full ticks of mismatch, so stable time exceeds the delay
	assign accept = tick_i && (level_i != level_o) && (stable_cnt == limit_i);

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stable_cnt <= '0;
			level_o    <= 1'b0;
			rise_o     <= 1'b0;
			fall_o     <= 1'b0;
		end
		else
		begin
			rise_o <= accept && level_i;
			fall_o <= accept && !level_i;
			if (level_i == level_o)
				stable_cnt <= '0;
			else if (accept)
			begin
				level_o    <= level_i;
				stable_cnt <= '0;
			end
			else if (tick_i)
				stable_cnt <= stable_cnt + 9'h1;
		end
	end
endmodule

// ---- hdl/gec_channel.sv ----
// Gated 32-bit edge counter channel with compare flag, diagnostics and register port
`timescale 1ns/1ps
`include "gec_regs.svh"
module gec_channel
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_i,
	input  wire logic [`GEC_ADDR_W-1:0]  addr_i,
	input  wire gec_pkg::gec_word_t      wr_data_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output gec_pkg::gec_word_t           rd_data_o,
	input  wire logic                    count_in_i,
	input  wire logic                    wire_break_i,
	input  wire logic                    supply_low_i,
	output logic                         compare_output_flag_o,
	output logic                         internal_gate_status_o,
	output logic                         diag_fault_o,
	output logic                         irq_o
);
	import gec_pkg::*;

	// ================================================================
	// Registers
	gec_word_t              ctrl;
	gec_word_t              high_lim;
	gec_word_t              cmp_val;
	gec_word_t              start_val;
	gec_word_t              count;
	logic [`GEC_IRQ_W-1:0]  irq_sts;
	logic [`GEC_IRQ_W-1:0]  irq_mask;
	logic                   gate;
	logic                   cmp_flag;
	logic                   sw_prev;
	logic                   wire_fault;
	logic                   supply_fault;
	logic                   diag_prev;

	// ================================================================
	// Decode
	wire logic wr_ctrl  = wr_i && (addr_i == `GEC_OFS_CTRL);
	wire logic wr_high  = wr_i && (addr_i == `GEC_OFS_HIGH_LIM);
	wire logic wr_cmp   = wr_i && (addr_i == `GEC_OFS_CMP_VAL);
	wire logic wr_start = wr_i && (addr_i == `GEC_OFS_START_VAL);
	wire logic wr_ists  = wr_i && (addr_i == `GEC_OFS_IRQ_STS);
	wire logic wr_imask = wr_i && (addr_i == `GEC_OFS_IRQ_MASK);

	wire logic       software_gate_bit    = ctrl[`GEC_CTRL_SOFTWARE_GATE_BIT];
	wire logic [2:0] load_cmd   = ctrl[`GEC_CTRL_LOAD_HI:`GEC_CTRL_LOAD_LO];
	wire gec_edge_t  edge_sel   = gec_edge_t'(ctrl[`GEC_CTRL_EDGE_HI:`GEC_CTRL_EDGE_LO]);
	wire logic       cmp_lower  = ctrl[`GEC_CTRL_CMP_LOWER];
	wire logic       cont_mode  = ctrl[`GEC_CTRL_CONTINUE];
	wire logic       irq_en     = ctrl[`GEC_CTRL_IRQ_EN];
	wire logic       sup_diag   = ctrl[`GEC_CTRL_SUP_DIAG];
	wire logic       wire_diag  = ctrl[`GEC_CTRL_WIRE_DIAG];
	wire logic [2:0] flt_sel    = ctrl[`GEC_CTRL_FLT_HI:`GEC_CTRL_FLT_LO];

	wire gec_word_t status_word = {27'h0, software_gate_bit && !gate, wire_fault, supply_fault, gate, cmp_flag};

	wire gec_word_t rd_mux =
		(addr_i == `GEC_OFS_CTRL)      ? ctrl :
		(addr_i == `GEC_OFS_HIGH_LIM)  ? high_lim :
		(addr_i == `GEC_OFS_CMP_VAL)   ? cmp_val :
		(addr_i == `GEC_OFS_START_VAL) ? start_val :
		(addr_i == `GEC_OFS_COUNT)     ? count :
		(addr_i == `GEC_OFS_STATUS)    ? status_word :
		(addr_i == `GEC_OFS_IRQ_STS)   ? {29'h0, irq_sts} :
		(addr_i == `GEC_OFS_IRQ_MASK)  ? {29'h0, irq_mask} : 32'h0000_0000;

	// ================================================================
	// Pin synchronisers
	logic [1:0] cnt_sync;
	logic [1:0] wb_sync;
	logic [1:0] sup_sync;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_sync <= 2'h0;
			wb_sync  <= 2'h0;
			sup_sync <= 2'h0;
		end
		else
		begin
			cnt_sync <= {cnt_sync[0], count_in_i};
			wb_sync  <= {wb_sync[0], wire_break_i};
			sup_sync <= {sup_sync[0], supply_low_i};
		end
	end

	// ================================================================
	// Filter tick divider and delay selection
	logic [10:0] tick_div;
	logic        tick;
	wire logic   tick_wrap = (tick_div == 11'(`GEC_TICK_CYCLES - 1));

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tick_div <= 11'h0;
			tick     <= 1'b0;
		end
		else
		begin
			tick     <= tick_wrap;
			tick_div <= tick_wrap ? 11'h0 : tick_div + 11'h1;
		end
	end

	wire gec_ticks_t flt_ticks =
		(flt_sel == 3'h0) ? 9'(`GEC_DLY0_US / `GEC_TICK_US) :
		(flt_sel == 3'h1) ? 9'(`GEC_DLY1_US / `GEC_TICK_US) :
		(flt_sel == 3'h2) ? 9'(`GEC_DLY2_US / `GEC_TICK_US) :
		(flt_sel == 3'h3) ? 9'(`GEC_DLY3_US / `GEC_TICK_US) :
		(flt_sel == 3'h4) ? 9'(`GEC_DLY4_US / `GEC_TICK_US) :
		(flt_sel == 3'h5) ? 9'(`GEC_DLY5_US / `GEC_TICK_US) : 9'(`GEC_DLY6_US / `GEC_TICK_US);

	logic flt_level;
	logic flt_rise;
	logic flt_fall;

	gec_filter u_filter (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick),
		.level_i   (cnt_sync[1]),
		.limit_i   (flt_ticks),
		.level_o   (flt_level),
		.rise_o    (flt_rise),
		.fall_o    (flt_fall)
	);

	// ================================================================
	// Counting
	// edge selection
	wire logic cnt_ev =
		(edge_sel == GEC_EDGE_FALL) ? flt_fall :
		(edge_sel == GEC_EDGE_BOTH) ? (flt_rise || flt_fall) : flt_rise;
	wire logic sw_rise = software_gate_bit && !sw_prev;
	wire logic step    = gate && software_gate_bit && cnt_ev;
	// A lowered high limit below the count also counts as passing it
	wire logic exceed  = step && (count >= high_lim);
	wire logic stop_ev = exceed && !cont_mode;

	gec_word_t next_count;
	logic      next_gate;

	always_comb
	begin
		next_count = count;
		next_gate  = gate;
		if (!software_gate_bit)
			next_gate = 1'b0;
		else if (sw_rise)
		begin
			// only a fresh set of the gate bit reopens
			next_gate = 1'b1;
			if (load_cmd == `GEC_LOAD_START)
				next_count = start_val;
		end
		else if (exceed)
		begin
			// the opposite limit is always zero
			next_count = `GEC_LOW_LIMIT;
			// stop mode closes the internal gate
			next_gate  = cont_mode;
		end
		else if (step)
			next_count = count + 32'h1;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			count   <= 32'h0000_0000;
			gate    <= 1'b0;
			sw_prev <= 1'b0;
		end
		else
		begin
			count   <= next_count;
			gate    <= next_gate;
			sw_prev <= software_gate_bit;
		end
	end

	// ================================================================
	// Compare flag; low limit is zero so the lower bound always holds
	// upper range, lower range, cleared outside
	wire logic in_range = cmp_lower ? (count <= cmp_val) : ((cmp_val <= count) && (count <= high_lim));

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			cmp_flag <= 1'b0;
		else
			cmp_flag <= in_range;
	end

	wire logic cmp_rise = in_range && !cmp_flag;

	// ================================================================
	// Diagnostics
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wire_fault   <= 1'b0;
			supply_fault <= 1'b0;
			diag_prev    <= 1'b0;
		end
		else
		begin
			wire_fault   <= wire_diag && wb_sync[1];
			supply_fault <= sup_diag && sup_sync[1];
			diag_prev    <= wire_fault || supply_fault;
		end
	end

	wire logic diag_rise = (wire_fault || supply_fault) && !diag_prev;

	// ================================================================
	// Register writes and interrupts
	// compare interrupt only with the option on
	wire logic [`GEC_IRQ_W-1:0] irq_set = {diag_rise, exceed, cmp_rise && irq_en};

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl      <= `GEC_CTRL_RST;
			high_lim  <= `GEC_HIGH_LIM_RST;
			cmp_val   <= `GEC_CMP_VAL_RST;
			start_val <= `GEC_START_VAL_RST;
			irq_sts   <= '0;
			irq_mask  <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= wr_data_i & `GEC_CTRL_MASK;
			if (wr_high)
				high_lim <= wr_data_i;
			if (wr_cmp)
				cmp_val <= wr_data_i;
			if (wr_start)
				start_val <= wr_data_i;
			if (wr_imask)
				irq_mask <= wr_data_i[`GEC_IRQ_W-1:0];
			// Set wins over a same-cycle clear
			irq_sts <= (irq_sts & ~(wr_ists ? wr_data_i[`GEC_IRQ_W-1:0] : 3'h0)) | irq_set;
		end
	end

	// ================================================================
	// Outputs
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_data_o              <= 32'h0000_0000;
			compare_output_flag_o  <= 1'b0;
			internal_gate_status_o <= 1'b0;
			diag_fault_o           <= 1'b0;
			irq_o                  <= 1'b0;
		end
		else
		begin
			rd_data_o              <= rd_i ? rd_mux : 32'h0000_0000;
			compare_output_flag_o  <= cmp_flag;
			internal_gate_status_o <= gate;
			diag_fault_o           <= wire_fault || supply_fault;
			irq_o                  <= |(irq_sts & irq_mask);
		end
	end

	// ================================================================
	// Assertions
	a_filter_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$changed(flt_level) |-> (flt_level == $past(cnt_sync[1])) && $past(tick))
		else $error("filtered level changed without a tick or against the input");

	a_irq_cmp_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!irq_en |=> !$rose(irq_sts[`GEC_IRQ_CMP]))
		else $error("compare interrupt raised while disabled");

	a_upper_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!cmp_lower && cmp_val <= count && count <= high_lim) |=> cmp_flag)
		else $error("compare flag not set in upper range");

	a_lower_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(cmp_lower && count <= cmp_val) |=> cmp_flag)
		else $error("compare flag not set in lower range");

	a_out_of_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!in_range |=> !cmp_flag ##1 !compare_output_flag_o)
		else $error("compare flag held outside range");

	a_count_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(step && !exceed && !sw_rise) |=> count == $past(count) + 32'h1)
		else $error("count did not step by one");

	a_start_load: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sw_rise && load_cmd == `GEC_LOAD_START) |=> count == $past(start_val) && gate)
		else $error("start value not loaded at gate opening");

	a_stop_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(stop_ev && !sw_rise) |=> !gate && count == `GEC_LOW_LIMIT)
		else $error("stop on limit did not close gate");

	a_restart_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!gate && software_gate_bit && sw_prev) |=> !gate)
		else $error("gate reopened without clear and set");

	a_wrap_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(exceed && cont_mode && !sw_rise) |=> gate && count == `GEC_LOW_LIMIT)
		else $error("continue mode did not wrap to zero");

	a_gate_closed: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(!gate && !sw_rise) |=> $stable(count))
		else $error("count moved with gate closed");

	a_diag_fault: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wire_diag && wb_sync[1]) |=> ##1 diag_fault_o)
		else $error("wire break not reported");

	a_supply_fault: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sup_diag && sup_sync[1]) |=> ##1 diag_fault_o)
		else $error("supply fault not reported");
endmodule

// ---- dv/gec_encoder_model.sv ----
// Behavioural pulse encoder that drives the counting input of the channel
`timescale 1ns/1ps
module gec_encoder_model
#(
	parameter int HOLD   = 4200,
	parameter int GLITCH = 100
)
(
	input  wire logic ref_clk_i,
	input  wire logic start_i,
	input  wire logic short_i,
	output logic      level_o = 1'b0,
	output logic      busy_o  = 1'b0
);
	// ================================================================
	// Pulse generator
	// Each level outlasts two filter ticks, so even the slowest accepted step lands
	// inside it; the short pulse stays below one tick and must be ignored
	always @(posedge ref_clk_i)
	begin
		if (start_i || short_i)
		begin
			busy_o  <= 1'b1;
			level_o <= 1'b1;
			repeat (short_i ? GLITCH : HOLD) @(posedge ref_clk_i);
			level_o <= 1'b0;
			repeat (HOLD) @(posedge ref_clk_i);
			busy_o  <= 1'b0;
		end
	end
endmodule

// ---- dv/gec_channel_tb.sv ----
// Self-checking testbench of the gated edge counter channel
`timescale 1ns/1ps
`include "gec_regs.svh"
`define CHK(nm, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("BAD %s exp %h got %h", nm, exp, got); \
		end \
	end
module gated_edge_counter_channel_tb_top;
	import gec_pkg::*;
	logic                   ref_clk_i    = 1'b0;
	logic                   rst_i        = 1'b1;
	logic [`GEC_ADDR_W-1:0] addr_i       = '0;
	gec_word_t              wr_data_i    = '0;
	logic                   wr_i         = 1'b0;
	logic                   rd_i         = 1'b0;
	logic                   wire_break_i = 1'b0;
	logic                   supply_low_i = 1'b0;
	logic                   enc_start    = 1'b0;
	logic                   enc_short    = 1'b0;
	gec_word_t              rd_data_o;
	logic                   count_in_i;
	logic                   enc_busy;
	logic                   flag_o;
	logic                   gate_o;
	logic                   diag_o;
	logic                   irq_o;
	int                     error_cnt    = 0;
	int                     n_checks     = 0;

	always #12.5 ref_clk_i = ~ref_clk_i;

	gec_channel i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .count_in_i(count_in_i),
		.wire_break_i(wire_break_i), .supply_low_i(supply_low_i), .compare_output_flag_o(flag_o),
		.internal_gate_status_o(gate_o), .diag_fault_o(diag_o), .irq_o(irq_o));
	gec_encoder_model i_enc (.ref_clk_i(ref_clk_i), .start_i(enc_start), .short_i(enc_short),
		.level_o(count_in_i), .busy_o(enc_busy));

	// ================================================================
	// Bus and stimulus tasks
	task automatic close_out;
	begin
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task automatic wr(input logic [7:0] a, input gec_word_t d);
	begin
		@(posedge ref_clk_i) wr_i <= 1'b1; addr_i <= a; wr_data_i <= d;
		@(posedge ref_clk_i) wr_i <= 1'b0;
	end
	endtask
	task automatic chk_rd(input string nm, input logic [7:0] a, input gec_word_t e);
	begin
		@(posedge ref_clk_i) rd_i <= 1'b1; addr_i <= a;
		@(posedge ref_clk_i) rd_i <= 1'b0;
		@(negedge ref_clk_i);
		`CHK(nm, e, rd_data_o)
	end
	endtask
	// Flags are registered copies, so let a few edges pass before looking
	task automatic settle;
	begin
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	end
	endtask
	task automatic pulse(input logic short);
		int i;
	begin
		@(posedge ref_clk_i) if (short) enc_short <= 1'b1; else enc_start <= 1'b1;
		@(posedge ref_clk_i) enc_short <= 1'b0; enc_start <= 1'b0;
		@(posedge ref_clk_i);
		for (i = 0; i < 20000 && enc_busy === 1'b1; i++) @(posedge ref_clk_i);
		if (enc_busy !== 1'b0)
		begin
			error_cnt++;
			$display("BAD encoder_done exp 0 got %b", enc_busy);
			close_out;
		end
		else
			repeat (20) @(posedge ref_clk_i);
	end
	endtask

	// ================================================================
	// Scenarios
	task automatic t_reset;
	begin
		chk_rd("ctrl", `GEC_OFS_CTRL, `GEC_CTRL_RST);
		chk_rd("high", `GEC_OFS_HIGH_LIM, 32'hffff_ffff);
		chk_rd("cmp", `GEC_OFS_CMP_VAL, 32'h0000_0001);
		chk_rd("start", `GEC_OFS_START_VAL, 32'h0000_0000);
		chk_rd("count", `GEC_OFS_COUNT, 32'h0000_0000);
		chk_rd("irq_sts", `GEC_OFS_IRQ_STS, 32'h0000_0000);
		wr(8'h20, 32'h1234_5678);
		chk_rd("unmapped", 8'h20, 32'h0000_0000);
		wr(`GEC_OFS_CTRL, 32'hffff_c000);
		chk_rd("ctrl_upper", `GEC_OFS_CTRL, 32'h0000_0000);
		$display("test reset done");
	end
	endtask
	task automatic t_rise;
	begin
		// Start value kept between the limits
		wr(`GEC_OFS_START_VAL, 32'h0000_0005);
		wr(`GEC_OFS_CTRL, 32'h0000_0005);
		settle;
		chk_rd("count_load", `GEC_OFS_COUNT, 32'h0000_0005);
		`CHK("gate_open", 1'b1, gate_o)
		pulse(1'b0);
		pulse(1'b0);
		chk_rd("count_rise", `GEC_OFS_COUNT, 32'h0000_0007);
		pulse(1'b1);
		chk_rd("count_glitch", `GEC_OFS_COUNT, 32'h0000_0007);
		$display("test rise done");
	end
	endtask
	task automatic t_edges;
	begin
		wr(`GEC_OFS_CTRL, 32'h0000_0000);
		pulse(1'b0);
		chk_rd("count_closed", `GEC_OFS_COUNT, 32'h0000_0007);
		wr(`GEC_OFS_CTRL, 32'h0000_0021);
		pulse(1'b0);
		chk_rd("count_both", `GEC_OFS_COUNT, 32'h0000_0009);
		wr(`GEC_OFS_CTRL, 32'h0000_0011);
		pulse(1'b0);
		chk_rd("count_fall", `GEC_OFS_COUNT, 32'h0000_000a);
		$display("test edges done");
	end
	endtask
	task automatic t_cmp;
	begin
		wr(`GEC_OFS_CTRL, 32'h0000_0111);
		wr(`GEC_OFS_IRQ_MASK, 32'h0000_0001);
		wr(`GEC_OFS_CMP_VAL, 32'h0000_000b);
		settle;
		`CHK("flag_below", 1'b0, flag_o)
		wr(`GEC_OFS_CMP_VAL, 32'h0000_000a);
		settle;
		`CHK("flag_equal", 1'b1, flag_o)
		`CHK("irq_rise", 1'b1, irq_o)
		wr(`GEC_OFS_HIGH_LIM, 32'h0000_0009);
		settle;
		`CHK("flag_above_high", 1'b0, flag_o)
		wr(`GEC_OFS_HIGH_LIM, 32'hffff_ffff);
		wr(`GEC_OFS_IRQ_STS, 32'h0000_0007);
		settle;
		`CHK("irq_cleared", 1'b0, irq_o)
		wr(`GEC_OFS_CTRL, 32'h0000_0151);
		wr(`GEC_OFS_CMP_VAL, 32'h0000_0009);
		settle;
		`CHK("flag_lower_out", 1'b0, flag_o)
		wr(`GEC_OFS_IRQ_MASK, 32'h0000_0000);
		wr(`GEC_OFS_CMP_VAL, 32'h0000_000a);
		settle;
		`CHK("flag_lower_in", 1'b1, flag_o)
		`CHK("irq_masked", 1'b0, irq_o)
		chk_rd("irq_sts_set", `GEC_OFS_IRQ_STS, 32'h0000_0001);
		wr(`GEC_OFS_CTRL, 32'h0000_0051);
		wr(`GEC_OFS_IRQ_STS, 32'h0000_0007);
		wr(`GEC_OFS_CMP_VAL, 32'h0000_0009);
		wr(`GEC_OFS_CMP_VAL, 32'h0000_000a);
		settle;
		chk_rd("irq_sts_off", `GEC_OFS_IRQ_STS, 32'h0000_0000);
		$display("test compare done");
	end
	endtask
	task automatic t_limit;
	begin
		wr(`GEC_OFS_CTRL, 32'h0000_0001);
		wr(`GEC_OFS_HIGH_LIM, 32'h0000_000a);
		pulse(1'b0);
		chk_rd("count_stop", `GEC_OFS_COUNT, 32'h0000_0000);
		`CHK("gate_stop", 1'b0, gate_o)
		chk_rd("irq_limit", `GEC_OFS_IRQ_STS, 32'h0000_0002);
		pulse(1'b0);
		wr(`GEC_OFS_CTRL, 32'h0000_0001);
		settle;
		chk_rd("count_held", `GEC_OFS_COUNT, 32'h0000_0000);
		`CHK("gate_held", 1'b0, gate_o)
		chk_rd("status_wait", `GEC_OFS_STATUS, 32'h0000_0010);
		wr(`GEC_OFS_CTRL, 32'h0000_0000);
		wr(`GEC_OFS_CTRL, 32'h0000_0001);
		settle;
		`CHK("gate_restart", 1'b1, gate_o)
		pulse(1'b0);
		chk_rd("count_restart", `GEC_OFS_COUNT, 32'h0000_0001);
		wr(`GEC_OFS_CTRL, 32'h0000_0081);
		wr(`GEC_OFS_HIGH_LIM, 32'h0000_0001);
		pulse(1'b0);
		chk_rd("count_wrap", `GEC_OFS_COUNT, 32'h0000_0000);
		`CHK("gate_continue", 1'b1, gate_o)
		$display("test limit done");
	end
	endtask
	task automatic t_diag;
	begin
		wr(`GEC_OFS_CTRL, 32'h0000_0000);
		wire_break_i <= 1'b1;
		settle;
		`CHK("diag_off", 1'b0, diag_o)
		wr(`GEC_OFS_CTRL, 32'h0000_0400);
		settle;
		`CHK("diag_wire", 1'b1, diag_o)
		@(posedge ref_clk_i) wire_break_i <= 1'b0;
		wr(`GEC_OFS_CTRL, 32'h0000_0200);
		settle;
		`CHK("diag_clear", 1'b0, diag_o)
		@(posedge ref_clk_i) supply_low_i <= 1'b1;
		settle;
		`CHK("diag_supply", 1'b1, diag_o)
		chk_rd("status_supply", `GEC_OFS_STATUS, 32'h0000_0004);
		chk_rd("irq_diag", `GEC_OFS_IRQ_STS, 32'h0000_0006);
		@(posedge ref_clk_i) supply_low_i <= 1'b0;
		$display("test diag done");
	end
	endtask

	// ================================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_rise;
		t_edges;
		t_cmp;
		t_limit;
		t_diag;
		close_out;
	end
endmodule
